// ### bench/cpm_gain_sva.sv
// checker for the gain stage: bus answer, output strobe and sign relations
// assumes binding to cpm_gain built with 16-bit samples
`timescale 1ns/1ps
module cpm_gain_sva (
  input wire CLK_I, input wire ARST_N_I, input wire PSEL_I, input wire PENABLE_I,
  input wire PREADY_O, input wire SAMPLE_VALID_I, input wire CALL_PROGRESS_VALID_O,
  input wire signed [15:0] RX_SAMPLE_I, input wire signed [15:0] TX_SAMPLE_I,
  input wire signed [15:0] CALL_PROGRESS_OUTPUT_O);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_setup; PSEL_I && !PENABLE_I; endsequence
  sequence s_pos; SAMPLE_VALID_I && !RX_SAMPLE_I[15] && !TX_SAMPLE_I[15]; endsequence
  a_ready_setup: assert property (s_setup |=> PREADY_O)
    else $error("no ready after setup");
  a_valid_next: assert property (SAMPLE_VALID_I |=> CALL_PROGRESS_VALID_O)
    else $error("no output strobe");
  a_out_hold: assert property (!CALL_PROGRESS_VALID_O |-> $stable(CALL_PROGRESS_OUTPUT_O))
    else $error("output moved without strobe");
  a_zero_in: assert property (SAMPLE_VALID_I && RX_SAMPLE_I == 0 && TX_SAMPLE_I == 0
    |=> CALL_PROGRESS_OUTPUT_O == 0) else $error("zero input not zero");
  a_pos_sat: assert property (s_pos |=> !CALL_PROGRESS_OUTPUT_O[15])
    else $error("positive sum wrapped");
  a_neg_sat: assert property (SAMPLE_VALID_I && RX_SAMPLE_I[15] && TX_SAMPLE_I[15]
    |=> CALL_PROGRESS_OUTPUT_O <= 0) else $error("negative sum wrapped");
endmodule
bind cpm_gain cpm_gain_sva i_cpm_gain_sva (.*);

// ### bench/tb.sv
// self-checking bench for cpm_gain: register access and scaled sums
// assumes cpm_gain with defaults and its header on the include path
`timescale 1ns/1ps
module tb;
  reg CLK_I = 0, ARST_N_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0, SAMPLE_VALID_I = 0;
  reg [11:0] PADDR_I = 0;
  reg [31:0] PWDATA_I = 0, r;
  reg [3:0] PSTRB_I = 4'hF;
  reg e = 0;
  reg signed [15:0] RX_SAMPLE_I = 0, TX_SAMPLE_I = 0;
  wire [31:0] PRDATA_O;
  wire PREADY_O, PSLVERR_O, CALL_PROGRESS_VALID_O;
  wire signed [15:0] CALL_PROGRESS_OUTPUT_O;
  integer error_cnt = 0, n_tests = 0, grx = 0, gtx = 0, s;
  cpm_gain i_cpm_gain (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .RX_SAMPLE_I(RX_SAMPLE_I), .TX_SAMPLE_I(TX_SAMPLE_I), .SAMPLE_VALID_I(SAMPLE_VALID_I),
    .CALL_PROGRESS_OUTPUT_O(CALL_PROGRESS_OUTPUT_O),
    .CALL_PROGRESS_VALID_O(CALL_PROGRESS_VALID_O));
  initial begin
    forever #5 CLK_I = ~CLK_I;
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge CLK_I);
    PSEL_I <= 1; PENABLE_I <= 0; PWRITE_I <= w; PADDR_I <= a; PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1;
    do @(posedge CLK_I); while (PREADY_O !== 1'b1);
    r = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I <= 0; PENABLE_I <= 0;
  endtask
  task gains(input [7:0] a, input [7:0] b);
    apb(1, 12'h050, {24'hFFFFFF, a}); apb(1, 12'h054, {24'h0, b}); grx = a; gtx = b;
  endtask
  // floor scaling, then clamp instead of wrapping
  task smp(input signed [15:0] rx, input signed [15:0] tx);
    @(posedge CLK_I);
    RX_SAMPLE_I <= rx; TX_SAMPLE_I <= tx; SAMPLE_VALID_I <= 1;
    @(posedge CLK_I);
    SAMPLE_VALID_I <= 0;
    @(posedge CLK_I);
    s = ((rx * grx) >>> 6) + ((tx * gtx) >>> 6);
    s = s > 32767 ? 32767 : (s < -32768 ? -32768 : s);
    chk("valid", {31'h0, CALL_PROGRESS_VALID_O}, 32'h1);
    chk("output", {16'h0, CALL_PROGRESS_OUTPUT_O}, {16'h0, s[15:0]});
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge CLK_I);
    ARST_N_I <= 1;
    repeat (3) @(posedge CLK_I);
    apb(0, 12'h050, 0); chk("rx gain reset", r, 0);
    apb(0, 12'h054, 0); chk("tx gain reset", r, 0);
    gains(8'h40, 8'h00); smp(1000, 500); smp(0, 0);
    gains(8'h00, 8'h40); smp(1000, -500);
    gains(8'hFF, 8'h20); smp(100, -100); smp(-7, 3);
    apb(0, 12'h050, 0); chk("rx gain", r, 32'hFF);
    apb(0, 12'h054, 0); chk("tx gain", r, 32'h20);
    gains(8'hFF, 8'hFF); smp(16'sh7000, 16'sh7000); smp(-16'sh7000, -16'sh7000);
    apb(0, 12'h058, 0); chk("output view", r, 32'hFFFF8000);
    chk("view error", {31'h0, e}, 32'h0);
    apb(1, 12'h058, 32'h1234); chk("ro write error", {31'h0, e}, 32'h1);
    apb(0, 12'h05C, 0); chk("unmapped error", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
    final_report;
  end
endmodule

// ### hw/cpm_gain.v
// call-progress monitor gain stage: two 8-bit linear gains, mute, saturating sum
// assumes an APB master on CLK_I and sample streams synchronous to CLK_I
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "cpm_regs.vh"

module cpm_gain #(
  parameter SAMPLE_W = 16,
  parameter ADDR_W = 12
) (
  // clock and reset
  input wire CLK_I,
  input wire ARST_N_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [ADDR_W-1:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [3:0] PSTRB_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  // sample streams
  input wire signed [SAMPLE_W-1:0] RX_SAMPLE_I,
  input wire signed [SAMPLE_W-1:0] TX_SAMPLE_I,
  input wire SAMPLE_VALID_I,
  // monitor output
  output reg signed [SAMPLE_W-1:0] CALL_PROGRESS_OUTPUT_O,
  output reg CALL_PROGRESS_VALID_O
);

  localparam SCL_W = SAMPLE_W + 9 - `CPM_GAIN_FRAC;

  // internal reset: asserts at once, lifts two edges after the pin rises
  wire rst_n;
  cpm_rst_sync i_cpm_rst_sync (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .rst_n_o(rst_n)
  );

  wire [7:0] rx_monitor_gain;
  wire [7:0] tx_monitor_gain;

  // address decode, shared by the read mux and the write enables
  wire hit_rx;
  wire hit_tx;
  wire hit_out;
  wire hit;
  cpm_addr_dec #(
    .ADDR_W(ADDR_W)
  ) i_cpm_addr_dec (
    .addr_i(PADDR_I),
    .hit_rx_o(hit_rx),
    .hit_tx_o(hit_tx),
    .hit_out_o(hit_out),
    .hit_o(hit)
  );

  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit_rx) begin
      next_rdata = {24'h00_0000, rx_monitor_gain};
    end else if (hit_tx) begin
      next_rdata = {24'h00_0000, tx_monitor_gain};
    end else if (hit_out) begin
      // read-only view of the last output sample, sign-extended
      next_rdata = {{(32-SAMPLE_W){CALL_PROGRESS_OUTPUT_O[SAMPLE_W-1]}},
                    CALL_PROGRESS_OUTPUT_O};
    end
  end

  // pready answers one cycle after setup; a write lands at the sampled edge
  wire setup = PSEL_I & ~PENABLE_I;
  wire wr_go = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & ~PSLVERR_O;
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PREADY_O <= setup;
      // writes to the read-only output view are refused too
      PSLVERR_O <= setup & (~hit | (PWRITE_I & hit_out));
      PRDATA_O <= (setup & ~PWRITE_I) ? next_rdata : 32'h0000_0000;
    end
  end

  // a refused write never reaches a register
  wire wr_rx = wr_go & PSTRB_I[0] & hit_rx;
  wire wr_tx = wr_go & PSTRB_I[0] & hit_tx;

  cpm_gain_reg #(
    .WIDTH(8),
    .RST_VAL(`CPM_RX_GAIN_RST)
  ) i_cpm_gain_reg_rx (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .wr_en_i(wr_rx),
    .wr_data_i(PWDATA_I[`CPM_GAIN_MSB:`CPM_GAIN_LSB]),
    .code_o(rx_monitor_gain)
  );

  cpm_gain_reg #(
    .WIDTH(8),
    .RST_VAL(`CPM_TX_GAIN_RST)
  ) i_cpm_gain_reg_tx (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .wr_en_i(wr_tx),
    .wr_data_i(PWDATA_I[`CPM_GAIN_MSB:`CPM_GAIN_LSB]),
    .code_o(tx_monitor_gain)
  );

  // one scaler per path keeps the two gains strictly independent
  wire signed [SCL_W-1:0] rx_scaled;
  wire signed [SCL_W-1:0] tx_scaled;

  cpm_gain_path #(
    .SAMPLE_W(SAMPLE_W),
    .CODE_W(8),
    .FRAC(`CPM_GAIN_FRAC)
  ) i_cpm_gain_path_rx (
    .sample_i(RX_SAMPLE_I),
    .code_i(rx_monitor_gain),
    .scaled_o(rx_scaled)
  );

  cpm_gain_path #(
    .SAMPLE_W(SAMPLE_W),
    .CODE_W(8),
    .FRAC(`CPM_GAIN_FRAC)
  ) i_cpm_gain_path_tx (
    .sample_i(TX_SAMPLE_I),
    .code_i(tx_monitor_gain),
    .scaled_o(tx_scaled)
  );

  // overflow clamps to full scale; wrapping would flip the tone's sign
  wire signed [SAMPLE_W-1:0] mixed;
  cpm_sat #(
    .IN_W(SCL_W),
    .OUT_W(SAMPLE_W)
  ) i_cpm_sat (
    .a_i(rx_scaled),
    .b_i(tx_scaled),
    .sat_o(mixed)
  );

  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CALL_PROGRESS_OUTPUT_O <= {SAMPLE_W{1'h0}};
      CALL_PROGRESS_VALID_O <= 1'h0;
    end else begin
      CALL_PROGRESS_VALID_O <= SAMPLE_VALID_I;
      if (SAMPLE_VALID_I) begin
        CALL_PROGRESS_OUTPUT_O <= mixed;
      end
    end
  end

endmodule

// reset release: asserts at once, lifts on the second edge after the pin rises
module cpm_rst_sync (
  // clock and raw reset
  input wire clk_i,
  input wire arst_n_i,
  // released reset
  output reg rst_n_o
);

  // only the second flop is read outside, so a late release cannot split
  reg rst_meta;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'h0;
      rst_n_o <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_n_o <= rst_meta;
    end
  end

endmodule

// address decode of the register window; one hit line per register
module cpm_addr_dec #(
  parameter ADDR_W = 12
) (
  // bus address
  input wire [ADDR_W-1:0] addr_i,
  // hits
  output reg hit_rx_o,
  output reg hit_tx_o,
  output reg hit_out_o,
  output reg hit_o
);

  // byte addresses are four times the register index
  wire [ADDR_W-1:0] addr_rx = {{(ADDR_W-10){1'h0}}, `CPM_RX_GAIN_IDX, 2'h0};
  wire [ADDR_W-1:0] addr_tx = {{(ADDR_W-10){1'h0}}, `CPM_TX_GAIN_IDX, 2'h0};
  wire [ADDR_W-1:0] addr_out = {{(ADDR_W-10){1'h0}}, `CPM_MON_OUT_IDX, 2'h0};

  always @* begin
    hit_rx_o = 1'h0;
    hit_tx_o = 1'h0;
    hit_out_o = 1'h0;
    hit_o = 1'h1;
    if (addr_i == addr_rx) begin
      hit_rx_o = 1'h1;
    end else if (addr_i == addr_tx) begin
      hit_tx_o = 1'h1;
    end else if (addr_i == addr_out) begin
      hit_out_o = 1'h1;
    end else begin
      hit_o = 1'h0;
    end
  end

endmodule

// one read/write code register with its own reset value
module cpm_gain_reg #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RST_VAL = 8'h00
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // write side
  input wire wr_en_i,
  input wire [WIDTH-1:0] wr_data_i,
  // held code
  output reg [WIDTH-1:0] code_o
);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_o <= RST_VAL;
    end else if (wr_en_i) begin
      code_o <= wr_data_i;
    end
  end

endmodule

// one gain path: linear scale by code over 2**FRAC, exact zero when muted
module cpm_gain_path #(
  parameter SAMPLE_W = 16,
  parameter CODE_W = 8,
  parameter FRAC = 6
) (
  // sample and code
  input wire signed [SAMPLE_W-1:0] sample_i,
  input wire [CODE_W-1:0] code_i,
  // scaled result
  output wire signed [SAMPLE_W+CODE_W-FRAC:0] scaled_o
);

  localparam PROD_W = SAMPLE_W + CODE_W + 1;
  localparam SCL_W = PROD_W - FRAC;

  // code is unsigned, so a zero goes in front before the signed multiply
  wire signed [CODE_W:0] code_s = $signed({1'h0, code_i});
  wire signed [PROD_W-1:0] prod = sample_i * code_s;
  // floor, not nearest: the shift rounds toward minus infinity
  wire signed [PROD_W-1:0] shr = prod >>> FRAC;
  wire mute = (code_i == {CODE_W{1'h0}});

  // a muted path must still be exact zero, whatever the sample
  assign scaled_o = mute ? {SCL_W{1'h0}}
                         : shr[SCL_W-1:0];

endmodule

// sum of two scaled paths, clamped to the output width
module cpm_sat #(
  parameter IN_W = 19,
  parameter OUT_W = 16
) (
  // scaled paths
  input wire signed [IN_W-1:0] a_i,
  input wire signed [IN_W-1:0] b_i,
  // clamped sum
  output wire signed [OUT_W-1:0] sat_o
);

  localparam SUM_W = IN_W + 1;
  localparam TOP_W = SUM_W - OUT_W + 1;

  // in range when the output sign bit and all bits above it agree
  wire signed [SUM_W-1:0] sum = {a_i[IN_W-1], a_i} + {b_i[IN_W-1], b_i};
  wire [TOP_W-1:0] top = sum[SUM_W-1:OUT_W-1];
  wire in_range = (top == {TOP_W{1'h0}}) | (top == {TOP_W{1'h1}});
  wire [OUT_W-1:0] clamp = sum[SUM_W-1] ? {1'h1, {(OUT_W-1){1'h0}}}
                                        : {1'h0, {(OUT_W-1){1'h1}}};

  assign sat_o = in_range ? sum[OUT_W-1:0] : clamp;

endmodule

// ### hw/cpm_regs.vh
// register map and constants of the call-progress monitor gain stage
// assumes inclusion by the design file only; definitions only
`ifndef CPM_REGS_VH
`define CPM_REGS_VH

// register indices; byte address is four times the index
`define CPM_RX_GAIN_IDX 8'h14
`define CPM_TX_GAIN_IDX 8'h15
`define CPM_MON_OUT_IDX 8'h16

// reset values
`define CPM_RX_GAIN_RST 8'h00
`define CPM_TX_GAIN_RST 8'h00

// gain code field and scaling
`define CPM_GAIN_LSB 0
`define CPM_GAIN_MSB 7
`define CPM_GAIN_UNITY 8'h40
`define CPM_GAIN_FRAC 6

`endif
